/* logic/pwmsdl_map.vh */
// register map, reset values and timing constants of the pwm sync front end
`ifndef PWMSDL_MAP_VH
`define PWMSDL_MAP_VH

// ****************************************************************
// registers
// ****************************************************************
`define PWMSDL_SEL_PHASE 1'b0
`define PWMSDL_SEL_DUTY 1'b1
`define PWMSDL_PH_CNT_HI 7
`define PWMSDL_PH_CNT_LO 6
`define PWMSDL_PH_RATE 5
`define PWMSDL_PH_OFS_HI 3
`define PWMSDL_DL_CEIL_HI 7
`define PWMSDL_DL_CEIL_LO 2
`define PWMSDL_OFS_RESET 4'h0
`define PWMSDL_RATE_RESET 1'b0
`define PWMSDL_CEIL_RESET 6'h3A

// ****************************************************************
// timing
// ****************************************************************
`define PWMSDL_SYS_KHZ 250000
`define PWMSDL_SYNC_KHZ 500
`define PWMSDL_PERIOD_CYC (`PWMSDL_SYS_KHZ / `PWMSDL_SYNC_KHZ)
`define PWMSDL_LOCK_TOL 16
`define PWMSDL_STEP_DEG 225

`endif

/* logic/pwmsdl_cycle.v */
// one pwm cycle: delayed start and clamped high-side on-time
`include "pwmsdl_map.vh"
module pwmsdl_cycle #(
  parameter CW = 10
) (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // cycle control
  input wire sync_fall_i,
  input wire run_i,
  input wire [CW-1:0] delay_cyc_i,
  input wire [CW-1:0] on_cyc_i,
  // drive
  output reg pwm_high_o,
  output reg cycle_start_o
);

  reg [CW-1:0] dly_q;
  reg dly_act_q;
  reg [CW-1:0] on_q;

  // ****************************************************************
  // phase delay, then on-phase
  // ****************************************************************
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      dly_q <= {CW{1'b0}};
      dly_act_q <= 1'b0;
      on_q <= {CW{1'b0}};
      pwm_high_o <= 1'b0;
      cycle_start_o <= 1'b0;
    end
    else
    begin
      cycle_start_o <= 1'b0;
      if (sync_fall_i && run_i)
      begin
        dly_q <= delay_cyc_i;
        dly_act_q <= 1'b1;
      end
      else if (dly_act_q)
      begin
        if (dly_q == {CW{1'b0}})
        begin
          dly_act_q <= 1'b0;
          // lock lost during the delay cancels the cycle
          if (run_i)
          begin
            cycle_start_o <= 1'b1;
            on_q <= on_cyc_i;
            pwm_high_o <= (on_cyc_i != {CW{1'b0}});
          end
        end
        else
          dly_q <= dly_q - {{(CW-1){1'b0}}, 1'b1};
      end
      if (pwm_high_o && !(dly_act_q && dly_q == {CW{1'b0}}))
      begin
        if (on_q <= {{(CW-1){1'b0}}, 1'b1})
          pwm_high_o <= 1'b0;
        else
          on_q <= on_q - {{(CW-1){1'b0}}, 1'b1};
      end
      if (!run_i)
        pwm_high_o <= 1'b0;
    end
  end

endmodule // pwmsdl_cycle

/* logic/pwmsdl_top.v */
// sync lock, phase interleave and duty limit front end of the pwm controller
`include "pwmsdl_map.vh"
module pwmsdl_top #(
  parameter CW = 10,
  parameter [1:0] PHASE_COUNT = 2'h0
) (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // sync line from the power manager
  input wire sync_line_i,
  // register access
  input wire reg_sel_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // regulation loop
  input wire [5:0] duty_req_i,
  input wire fault_req_i,
  // outputs
  output wire pwm_high_o,
  output wire cycle_start_o,
  output reg locked_o,
  output reg fault_o,
  output reg switch_rate_select_o
);

  localparam integer NOM_I = `PWMSDL_PERIOD_CYC;
  localparam integer TOL_I = `PWMSDL_LOCK_TOL;
  localparam [CW-1:0] NOM = NOM_I[CW-1:0];
  localparam [CW-1:0] TOL = TOL_I[CW-1:0];

  reg sync_m_q;
  reg sync_s_q;
  reg sync_p_q;
  wire sync_fall;
  reg [CW-1:0] cnt_q;
  reg [CW-1:0] period_q;
  reg [3:0] phase_offset_q;
  reg [5:0] duty_ceiling_q;
  reg [5:0] duty_eff;
  reg [CW+5:0] on_prod;
  reg [CW+3:0] dly_prod;
  reg [CW-1:0] on_cyc;
  reg [CW-1:0] dly_cyc;

  // ****************************************************************
  // sync line capture and falling edge
  // ****************************************************************
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sync_m_q <= 1'b1;
      sync_s_q <= 1'b1;
      sync_p_q <= 1'b1;
    end
    else
    begin
      sync_m_q <= sync_line_i;
      sync_s_q <= sync_m_q;
      sync_p_q <= sync_s_q;
    end
  end

  assign sync_fall = sync_p_q & ~sync_s_q;

  // ****************************************************************
  // period measurement and lock
  // ****************************************************************
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_q <= {CW{1'b0}};
      period_q <= NOM;
      locked_o <= 1'b0;
    end
    else if (sync_fall)
    begin
      cnt_q <= {CW{1'b0}};
      if (cnt_q + {{(CW-1){1'b0}}, 1'b1} >= NOM - TOL &&
          cnt_q + {{(CW-1){1'b0}}, 1'b1} <= NOM + TOL)
      begin
        period_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        locked_o <= 1'b1;
      end
      else
        locked_o <= 1'b0;
    end
    else if (cnt_q == {CW{1'b1}})
      locked_o <= 1'b0;
    else
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      phase_offset_q <= `PWMSDL_OFS_RESET;
      switch_rate_select_o <= `PWMSDL_RATE_RESET;
      duty_ceiling_q <= `PWMSDL_CEIL_RESET;
    end
    else if (reg_wr_i)
    begin
      if (reg_sel_i == `PWMSDL_SEL_PHASE)
      begin
        phase_offset_q <= reg_wdata_i[`PWMSDL_PH_OFS_HI:0];
        switch_rate_select_o <= reg_wdata_i[`PWMSDL_PH_RATE];
      end
      else
        duty_ceiling_q <=
          reg_wdata_i[`PWMSDL_DL_CEIL_HI:`PWMSDL_DL_CEIL_LO];
    end
  end

  always @*
  begin
    if (reg_sel_i == `PWMSDL_SEL_PHASE)
      reg_rdata_o = {PHASE_COUNT, switch_rate_select_o, 1'b0,
                     phase_offset_q};
    else
      reg_rdata_o = {duty_ceiling_q, 2'b00};
  end

  // ****************************************************************
  // delay and on-time from the locked period
  // ****************************************************************
  always @*
  begin
    duty_eff = (duty_req_i > duty_ceiling_q) ? duty_ceiling_q
                                             : duty_req_i;
    on_prod = period_q * duty_eff;
    dly_prod = period_q * phase_offset_q;
    on_cyc = on_prod[CW+5:6];
    dly_cyc = dly_prod[CW+3:4];
  end

  // ****************************************************************
  // fault status at falling sync edge
  // ****************************************************************
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      fault_o <= 1'b0;
    else if (sync_fall)
      fault_o <= fault_req_i;
  end

  pwmsdl_cycle #(
    .CW(CW)
  ) u_cycle (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .sync_fall_i(sync_fall),
    .run_i(locked_o),
    .delay_cyc_i(dly_cyc),
    .on_cyc_i(on_cyc),
    .pwm_high_o(pwm_high_o),
    .cycle_start_o(cycle_start_o)
  );

endmodule // pwmsdl_top

/* bench/pwmsdl_sync_model.sv */
// power manager model driving the shared sync clock
module pwmsdl_sync_model (
  // control
  input logic run_i,
  input logic [15:0] half_ns_i,
  // sync line, idles high between frames
  output logic sync_line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sync_line_o = 1'b1;
    forever
    begin
      wait (run_i);
      #(half_ns_i) sync_line_o = 1'b0;
      #(half_ns_i) sync_line_o = 1'b1;
    end
  end
endmodule // pwmsdl_sync_model

/* bench/pwmsdl_top_sva.sv */
// assertions on the ports of the pwm sync front end
module pwmsdl_top_sva #(
  parameter CW = 10,
  parameter [1:0] PHASE_COUNT = 2'h0
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire sync_line_i,
  input wire reg_sel_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire cycle_start_o,
  input wire pwm_high_o,
  input wire locked_o,
  input wire fault_o,
  input wire switch_rate_select_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_ph_wr;
    reg_wr_i && !reg_sel_i ##1 !reg_sel_i;
  endsequence
  sequence s_dl_wr;
    reg_wr_i && reg_sel_i ##1 reg_sel_i;
  endsequence
  a_phase_count:
    assert property (!reg_sel_i |-> reg_rdata_o[7:6] == PHASE_COUNT)
    else $error("phase count field wrong");
  a_rate_write:
    assert property (s_ph_wr |-> switch_rate_select_o == $past(reg_wdata_i[5])
      && reg_rdata_o[5] == switch_rate_select_o) else $error("rate bit wrong");
  a_offset_write:
    assert property (s_ph_wr |-> reg_rdata_o[3:0] == $past(reg_wdata_i[3:0]))
    else $error("phase offset not stored");
  a_ceil_write:
    assert property (s_dl_wr |-> reg_rdata_o[7:2] == $past(reg_wdata_i[7:2]))
    else $error("duty ceiling not stored");
  a_unused_zero:
    assert property (reg_sel_i ? reg_rdata_o[1:0] == 2'h0 : !reg_rdata_o[4])
    else $error("unused bit not zero");
  a_fault_edge:
    assert property ($changed(fault_o) |-> !$past(sync_line_i, 2)
      && $past(sync_line_i, 7)) else $error("fault changed off sync fall");
  a_start_locked:
    assert property (cycle_start_o |-> $past(locked_o))
    else $error("cycle started without lock");
  a_start_pulse:
    assert property (cycle_start_o |=> !cycle_start_o)
    else $error("cycle start longer than one cycle");
  a_high_at_start:
    assert property ($rose(pwm_high_o) |-> cycle_start_o)
    else $error("high side on outside cycle start");
endmodule // pwmsdl_top_sva
bind pwmsdl_top pwmsdl_top_sva #(.CW(CW), .PHASE_COUNT(PHASE_COUNT)) u_sva (
  .sys_clk_i(sys_clk_i),
  .reset_i(reset_i),
  .sync_line_i(sync_line_i),
  .reg_sel_i(reg_sel_i),
  .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .cycle_start_o(cycle_start_o),
  .pwm_high_o(pwm_high_o),
  .locked_o(locked_o),
  .fault_o(fault_o),
  .switch_rate_select_o(switch_rate_select_o)
);

/* bench/test_pwmsdl_top.sv */
// self-checking bench of the pwm sync front end
module test_pwmsdl_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, reg_sel_i = 1'b0, reg_wr_i = 1'b0;
  logic fault_req_i = 1'b0, run = 1'b0, sync_line_i;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic [5:0] duty_req_i = 6'h00;
  logic [15:0] half_ns = 16'h03E8;
  logic pwm_high_o, cycle_start_o, locked_o, fault_o, switch_rate_select_o;
  int mismatches = 0, num_checks = 0, dly, hi;
  pwmsdl_top #(.CW(10), .PHASE_COUNT(2'h0)) uut (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .sync_line_i(sync_line_i),
    .reg_sel_i(reg_sel_i),
    .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .duty_req_i(duty_req_i),
    .fault_req_i(fault_req_i),
    .pwm_high_o(pwm_high_o),
    .cycle_start_o(cycle_start_o),
    .locked_o(locked_o),
    .fault_o(fault_o),
    .switch_rate_select_o(switch_rate_select_o)
  );
  pwmsdl_sync_model mgr (.run_i(run), .half_ns_i(half_ns),
    .sync_line_o(sync_line_i));
  initial
  begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(logic sel, logic [7:0] d);
    reg_sel_i = sel;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rd(logic sel, logic [7:0] exp, string what);
    reg_sel_i = sel;
    tick(1);
    chk(what, {8'h00, exp}, {8'h00, reg_rdata_o});
  endtask
  // delay from sync fall to cycle start, then high-side cycles
  task automatic meas(output int d, output int h);
    @(negedge sync_line_i);
    d = 0;
    h = 0;
    while (cycle_start_o !== 1'b1 && d < 600)
    begin
      tick(1);
      d++;
    end
    while (pwm_high_o === 1'b1 && h < 600)
    begin
      h++;
      tick(1);
    end
  endtask
  initial
  begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial
  begin
    tick(2);
    reset_i = 1'b0;
    rd(1'b0, 8'h00, "phase reset");
    rd(1'b1, 8'hE8, "duty reset");
    wr(1'b0, 8'hDF);
    rd(1'b0, 8'h0F, "phase ones");
    chk("rate select", 16'h0, switch_rate_select_o);
    wr(1'b1, 8'hFF);
    rd(1'b1, 8'hFC, "duty ones");
    wr(1'b1, 8'h43);
    rd(1'b1, 8'h40, "duty ceiling");
    wr(1'b0, 8'h08);
    rd(1'b0, 8'h08, "phase offset");
    $display("register test done");
    duty_req_i = 6'h3F;
    fault_req_i = 1'b1;
    run = 1'b1;
    dly = 0;
    while (locked_o !== 1'b1 && dly < 2000)
    begin
      tick(1);
      dly++;
    end
    chk("locked", 16'h1, locked_o);
    meas(dly, hi);
    chk("offset delay", 16'h1, dly >= 253 && dly <= 255);
    chk("clamped on time", 16'h007D, hi);
    chk("fault status", 16'h1, fault_o);
    duty_req_i = 6'h04;
    fault_req_i = 1'b0;
    wr(1'b0, 8'h00);
    chk("fault held", 16'h1, fault_o);
    meas(dly, hi);
    chk("zero delay", 16'h1, dly >= 3 && dly <= 5);
    chk("loop on time", 16'h001F, hi);
    chk("fault cleared", 16'h0, fault_o);
    wr(1'b1, 8'h00);
    meas(dly, hi);
    chk("zero ceiling", 16'h0, hi);
    $display("pwm test done");
    half_ns = 16'h0028;
    tick(2000);
    chk("fast sync unlocked", 16'h0, locked_o);
    run = 1'b0;
    $display("lock test done");
    end_sim();
  end
endmodule // test_pwmsdl_top
